// [design/dtap_pkg.sv]
// Purpose: Shared constants and types of the debug test port block.
// Assumes: 32-bit register port, 5-bit instruction register.
// Notes:   Register offsets are byte addresses of aligned words.
package dtap_pkg;

	localparam int          DTAP_ADDR_W       = 8;
	localparam int          DTAP_DATA_W       = 32;
	localparam logic [7:0]  DTAP_OFS_CTRL     = 8'h00;
	localparam logic [7:0]  DTAP_OFS_STATUS   = 8'h04;
	localparam logic [7:0]  DTAP_OFS_IDCODE   = 8'h08;

	// Control word field positions.
	localparam int          DTAP_CTL_PERRST   = 0;
	localparam int          DTAP_CTL_PRRST    = 1;
	localparam int          DTAP_CTL_SRSTEN   = 2;
	localparam int          DTAP_CTL_W        = 3;
	localparam logic [2:0]  DTAP_CTL_RESET    = 3'h0;

	// Status word field positions.
	localparam int          DTAP_ST_DEBUG     = 0;
	localparam int          DTAP_ST_PEND      = 1;
	localparam int          DTAP_ST_SUP       = 2;
	localparam int          DTAP_ST_TAPRST    = 3;

	// Strap bus layout: support flag, revision, part, maker.
	localparam int          DTAP_STRAP_W      = 32;
	localparam int          DTAP_SB_SUP       = 31;
	localparam int          DTAP_SB_REV_LO    = 27;
	localparam int          DTAP_SB_PART_LO   = 11;
	localparam int          DTAP_SB_MAKER_LO  = 0;
	localparam int          DTAP_SYNC_W       = 37;

	// Identification word layout.
	localparam int          DTAP_ID_REV_LO    = 28;
	localparam int          DTAP_ID_PART_LO   = 12;
	localparam int          DTAP_ID_MAKER_LO  = 1;
	localparam logic        DTAP_ID_MARK      = 1'h1;

	// Instruction register.
	localparam int          DTAP_IR_W         = 5;
	localparam logic [4:0]  DTAP_IR_IDCODE    = 5'h01;
	localparam logic [4:0]  DTAP_IR_CONTROL   = 5'h0A;
	localparam logic [4:0]  DTAP_IR_BYPASS    = 5'h1F;
	localparam logic [4:0]  DTAP_IR_CAPTURE   = 5'h01;
	localparam int          DTAP_CDR_W        = 4;

	typedef enum logic [15:0] {
		DTAP_TLR  = 16'h0001,
		DTAP_RTI  = 16'h0002,
		DTAP_SDRS = 16'h0004,
		DTAP_CDR  = 16'h0008,
		DTAP_SHDR = 16'h0010,
		DTAP_E1DR = 16'h0020,
		DTAP_PDR  = 16'h0040,
		DTAP_E2DR = 16'h0080,
		DTAP_UDR  = 16'h0100,
		DTAP_SIRS = 16'h0200,
		DTAP_CIR  = 16'h0400,
		DTAP_SHIR = 16'h0800,
		DTAP_E1IR = 16'h1000,
		DTAP_PIR  = 16'h2000,
		DTAP_E2IR = 16'h4000,
		DTAP_UIR  = 16'h8000
	} dtap_state_type;

endpackage

// [design/dtap_pins_if.sv]
// Purpose: Carries the synchronised probe pins and straps to the port logic.
// Assumes: All signals are already in the clock domain of the core.
// Notes:   One producer, the synchroniser, and one consumer, the top.
`timescale 1ns/100ps
`default_nettype none
interface dtap_pins_if;
	logic        tck;
	logic        tms;
	logic        tdi;
	logic        trst_n;
	logic        dint;
	logic [31:0] straps;
	modport src (output tck, tms, tdi, trst_n, dint, straps);
	modport dst (input tck, tms, tdi, trst_n, dint, straps);
endinterface
`default_nettype wire

// [design/dtap_sync.sv]
// Purpose: Two-stage synchroniser for every pin that enters the block.
// Assumes: Pins are asynchronous to clock; straps are quasi static.
// Notes:   Only the second stage is visible outside this module.
`timescale 1ns/100ps
`default_nettype none
module dtap_sync
	import dtap_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [36:0] raw_in,
	dtap_pins_if.src         pins
);
	logic [DTAP_SYNC_W-1:0] stage1_reg;
	logic [DTAP_SYNC_W-1:0] stage2_reg;

	always_ff @(posedge clock) begin
		if (srst) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else begin
			stage1_reg <= raw_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign pins.tck    = stage2_reg[36];
	assign pins.tms    = stage2_reg[35];
	assign pins.tdi    = stage2_reg[34];
	assign pins.trst_n = stage2_reg[33];
	assign pins.dint   = stage2_reg[32];
	assign pins.straps = stage2_reg[31:0];
endmodule // dtap_sync
`default_nettype wire

// [design/dtap_top.sv]
// Purpose: Debug port of the core: debug mode flag, probe interrupt,
//          test access port with identification and control registers.
// Assumes: Probe pins and straps are asynchronous; clock is 200 MHz and
//          samples the test clock, which must stay well below clock/4.
// Notes:   Notes on behaviour follow.
// Notes on behaviour
// - Debug-mode output is high exactly while the core is in debug mode.
// - A debug request is taken only on a low-to-high change of the input.
// - Identification fields come straight from maker, part, revision straps.
// - The three reset request outputs never reset or affect the core.
// - The port runs on the test clock with serial in, out, mode select.
// - A tristate indication marks when the serial out pad must float.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module dtap_top
	import dtap_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        debug_entry,
	input  wire logic        debug_exit,
	output logic             debug_exc_req,
	output logic             in_debug_mode_out,
	input  wire logic        probe_debug_irq_in,
	input  wire logic        probe_irq_supported_strap,
	input  wire logic [10:0] maker_code_strap,
	input  wire logic [15:0] part_code_strap,
	input  wire logic [3:0]  revision_code_strap,
	output logic             peripheral_reset_req,
	output logic             processor_reset_req,
	output logic             soft_reset_enable_out,
	input  wire logic        test_clock_in,
	input  wire logic        test_serial_in,
	output logic             test_serial_out,
	output logic             test_out_highz_ind,
	input  wire logic        test_mode_select_in,
	input  wire logic        test_port_reset_n
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers.

	dtap_pins_if pins ();

	// All pins share one pair of stages, so mode select and data keep
	// their timing relative to the test clock.
	logic [DTAP_SYNC_W-1:0] raw_pins;
	assign raw_pins = {test_clock_in, test_mode_select_in, test_serial_in,
		test_port_reset_n, probe_debug_irq_in, probe_irq_supported_strap,
		revision_code_strap, part_code_strap, maker_code_strap};

	dtap_sync u_sync (
		.clock  (clock),
		.srst   (srst),
		.raw_in (raw_pins),
		.pins   (pins.src)
	);

	logic        dint_sup;
	logic [10:0] maker_code;
	logic [15:0] part_code;
	logic [3:0]  rev_code;
	assign dint_sup   = pins.straps[DTAP_SB_SUP];
	assign maker_code = pins.straps[DTAP_SB_MAKER_LO +: 11];
	assign part_code  = pins.straps[DTAP_SB_PART_LO +: 16];
	assign rev_code   = pins.straps[DTAP_SB_REV_LO +: 4];

	////////////////////////////////////////////////////////////////////////
	// Debug mode and probe interrupt.

	logic debug_mode_reg;
	logic dint_prev_reg;
	logic pending_reg;
	logic dint_rise;

	always_ff @(posedge clock) begin
		if (srst) begin
			debug_mode_reg <= 1'b0;
		end else if (debug_entry) begin
			debug_mode_reg <= 1'b1;
		end else if (debug_exit) begin
			debug_mode_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			dint_prev_reg <= 1'b0;
		end else begin
			dint_prev_reg <= pins.dint;
		end
	end

	assign dint_rise = pins.dint && !dint_prev_reg;

	// Entry beats a same-cycle rising change, since that change would land
	// inside debug mode and must be dropped anyway.
	always_ff @(posedge clock) begin
		if (srst) begin
			pending_reg <= 1'b0;
		end else if (debug_entry) begin
			pending_reg <= 1'b0;
		end else if (dint_rise && !debug_mode_reg && dint_sup) begin
			pending_reg <= 1'b1;
		end
	end

	assign debug_exc_req     = pending_reg;
	assign in_debug_mode_out = debug_mode_reg;

	////////////////////////////////////////////////////////////////////////
	// Test clock edges and port state machine.

	// The test clock is oversampled: each phase must last two core
	// clocks or more, or edges are lost.
	logic           tck_prev_reg;
	logic           tck_rise;
	logic           tck_fall;
	logic           tap_rst;
	dtap_state_type state_reg;
	dtap_state_type state_next;

	always_ff @(posedge clock) begin
		if (srst) begin
			tck_prev_reg <= 1'b0;
		end else begin
			tck_prev_reg <= pins.tck;
		end
	end

	assign tck_rise = pins.tck && !tck_prev_reg;
	assign tck_fall = !pins.tck && tck_prev_reg;
	assign tap_rst  = srst || !pins.trst_n;

	// The port reset comes from the synchronised pin, so its release never
	// lands in the middle of a detected test clock edge.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			DTAP_TLR:  state_next = pins.tms ? DTAP_TLR  : DTAP_RTI;
			DTAP_RTI:  state_next = pins.tms ? DTAP_SDRS : DTAP_RTI;
			DTAP_SDRS: state_next = pins.tms ? DTAP_SIRS : DTAP_CDR;
			DTAP_CDR:  state_next = pins.tms ? DTAP_E1DR : DTAP_SHDR;
			DTAP_SHDR: state_next = pins.tms ? DTAP_E1DR : DTAP_SHDR;
			DTAP_E1DR: state_next = pins.tms ? DTAP_UDR  : DTAP_PDR;
			DTAP_PDR:  state_next = pins.tms ? DTAP_E2DR : DTAP_PDR;
			DTAP_E2DR: state_next = pins.tms ? DTAP_UDR  : DTAP_SHDR;
			DTAP_UDR:  state_next = pins.tms ? DTAP_SDRS : DTAP_RTI;
			DTAP_SIRS: state_next = pins.tms ? DTAP_TLR  : DTAP_CIR;
			DTAP_CIR:  state_next = pins.tms ? DTAP_E1IR : DTAP_SHIR;
			DTAP_SHIR: state_next = pins.tms ? DTAP_E1IR : DTAP_SHIR;
			DTAP_E1IR: state_next = pins.tms ? DTAP_UIR  : DTAP_PIR;
			DTAP_PIR:  state_next = pins.tms ? DTAP_E2IR : DTAP_PIR;
			DTAP_E2IR: state_next = pins.tms ? DTAP_UIR  : DTAP_SHIR;
			DTAP_UIR:  state_next = pins.tms ? DTAP_SDRS : DTAP_RTI;
			default:   state_next = DTAP_TLR;
		endcase
	end

	always_ff @(posedge clock) begin
		if (tap_rst) begin
			state_reg <= DTAP_TLR;
		end else if (tck_rise) begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Instruction and data registers.

	logic [4:0]  ir_shift_reg;
	logic [4:0]  ir_reg;
	logic [31:0] dr_shift_reg;
	logic [2:0]  tap_ctl_reg;
	logic [31:0] id_word;

	assign id_word = {rev_code, part_code, maker_code, DTAP_ID_MARK};

	always_ff @(posedge clock) begin
		if (tap_rst) begin
			ir_shift_reg <= DTAP_IR_CAPTURE;
			ir_reg       <= DTAP_IR_IDCODE;
		end else if (tck_rise) begin
			case (state_reg)
				DTAP_TLR:  ir_reg       <= DTAP_IR_IDCODE;
				DTAP_CIR:  ir_shift_reg <= DTAP_IR_CAPTURE;
				DTAP_SHIR: ir_shift_reg <= {pins.tdi, ir_shift_reg[4:1]};
				DTAP_UIR:  ir_reg       <= ir_shift_reg;
				default:   ir_reg       <= ir_reg;
			endcase
		end
	end

	// Unknown instructions behave as bypass so a chain stays one bit long.
	always_ff @(posedge clock) begin
		if (tap_rst) begin
			dr_shift_reg <= '0;
		end else if (tck_rise && state_reg == DTAP_CDR) begin
			case (ir_reg)
				DTAP_IR_IDCODE:  dr_shift_reg <= id_word;
				DTAP_IR_CONTROL: dr_shift_reg <= {28'h0000000,
					debug_mode_reg, tap_ctl_reg};
				default:         dr_shift_reg <= '0;
			endcase
		end else if (tck_rise && state_reg == DTAP_SHDR) begin
			case (ir_reg)
				DTAP_IR_IDCODE:  dr_shift_reg <= {pins.tdi,
					dr_shift_reg[31:1]};
				DTAP_IR_CONTROL: dr_shift_reg[3:0] <= {pins.tdi,
					dr_shift_reg[3:1]};
				default:         dr_shift_reg[0] <= pins.tdi;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (tap_rst) begin
			tap_ctl_reg <= DTAP_CTL_RESET;
		end else if (tck_rise && state_reg == DTAP_UDR
				&& ir_reg == DTAP_IR_CONTROL) begin
			tap_ctl_reg <= dr_shift_reg[DTAP_CTL_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial output, changed on the falling test clock edge.

	logic tdo_reg;
	logic highz_reg;
	logic shifting;

	// Updating on the fall gives the probe half a test clock of setup
	// before it samples on the next rise.
	assign shifting = (state_reg == DTAP_SHDR) || (state_reg == DTAP_SHIR);

	always_ff @(posedge clock) begin
		if (tap_rst) begin
			tdo_reg   <= 1'b0;
			highz_reg <= 1'b1;
		end else if (tck_fall) begin
			tdo_reg   <= (state_reg == DTAP_SHIR) ? ir_shift_reg[0]
				: dr_shift_reg[0];
			highz_reg <= !shifting;
		end
	end

	assign test_serial_out    = tdo_reg;
	assign test_out_highz_ind = highz_reg;

	////////////////////////////////////////////////////////////////////////
	// Register port.

	// Software and the probe each hold a copy of the request bits; the
	// outputs are their OR, so neither side can clear what the other set.
	logic [2:0]  sw_ctl_reg;
	logic [31:0] rdata_reg;

	always_ff @(posedge clock) begin
		if (srst) begin
			sw_ctl_reg <= DTAP_CTL_RESET;
		end else if (reg_wr && reg_addr == DTAP_OFS_CTRL) begin
			sw_ctl_reg <= reg_wdata[DTAP_CTL_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_reg <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				DTAP_OFS_CTRL:   rdata_reg <= {29'h00000000, sw_ctl_reg};
				DTAP_OFS_STATUS: rdata_reg <= {28'h0000000,
					(state_reg == DTAP_TLR), dint_sup, pending_reg,
					debug_mode_reg};
				DTAP_OFS_IDCODE: rdata_reg <= id_word;
				default:         rdata_reg <= '0;
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end

	assign reg_rdata = rdata_reg;

	// These requests go out only; nothing inside the block or the core
	// listens to them.
	assign peripheral_reset_req  = sw_ctl_reg[DTAP_CTL_PERRST]
		| tap_ctl_reg[DTAP_CTL_PERRST];
	assign processor_reset_req   = sw_ctl_reg[DTAP_CTL_PRRST]
		| tap_ctl_reg[DTAP_CTL_PRRST];
	assign soft_reset_enable_out = sw_ctl_reg[DTAP_CTL_SRSTEN]
		| tap_ctl_reg[DTAP_CTL_SRSTEN];

endmodule // dtap_top
`default_nettype wire

// [sim/dtap_checker.sv]
// Purpose: Port assertions of the debug test port.
// Assumes: Straps stay still while they are read.
// Notes:   Bound to dtap_top from the bench top.
`timescale 1ns/100ps
`default_nettype none
module dtap_checker
	import dtap_pkg::*;
(
	input wire logic        clock,
	input wire logic        srst,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        debug_entry,
	input wire logic        debug_exit,
	input wire logic        debug_exc_req,
	input wire logic        in_debug_mode_out,
	input wire logic        probe_debug_irq_in,
	input wire logic        probe_irq_supported_strap,
	input wire logic [10:0] maker_code_strap,
	input wire logic [15:0] part_code_strap,
	input wire logic [3:0]  revision_code_strap,
	input wire logic        peripheral_reset_req,
	input wire logic        processor_reset_req,
	input wire logic        soft_reset_enable_out,
	input wire logic        test_out_highz_ind,
	input wire logic        test_port_reset_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	////////////////////////////////
	property p_enter;
		debug_entry |=> in_debug_mode_out && !debug_exc_req;
	endproperty
	a_enter: assert property (p_enter)
		else $error("entry left mode or request wrong");
	property p_exit;
		debug_exit && !debug_entry |=> !in_debug_mode_out;
	endproperty
	a_exit: assert property (p_exit)
		else $error("exit did not drop debug mode");
	property p_rise;
		$rose(probe_debug_irq_in) && probe_irq_supported_strap
			&& !in_debug_mode_out |-> ##[1:5] (debug_exc_req || in_debug_mode_out);
	endproperty
	a_rise: assert property (p_rise)
		else $error("rising request not taken");
	property p_quiet;
		($stable(probe_debug_irq_in))[*6] |=> !$rose(debug_exc_req);
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("request without a rising input");
	property p_in_dbg;
		in_debug_mode_out |=> !$rose(debug_exc_req);
	endproperty
	a_in_dbg: assert property (p_in_dbg)
		else $error("request taken in debug mode");
	property p_id;
		($stable({revision_code_strap, part_code_strap, maker_code_strap}))[*4]
			##0 (reg_rd && reg_addr == DTAP_OFS_IDCODE) |=> reg_rdata ==
			{revision_code_strap, part_code_strap, maker_code_strap, DTAP_ID_MARK};
	endproperty
	a_id: assert property (p_id)
		else $error("identification word wrong");
	property p_highz;
		(!test_port_reset_n)[*5] |-> test_out_highz_ind;
	endproperty
	a_highz: assert property (p_highz)
		else $error("serial out driven in port reset");
	property p_resout;
		$changed({peripheral_reset_req, processor_reset_req, soft_reset_enable_out})
			&& !$past(debug_entry) && !$past(debug_exit)
			|-> $stable(in_debug_mode_out);
	endproperty
	a_resout: assert property (p_resout)
		else $error("reset request disturbed the core");
	c_irq: cover property (debug_exc_req ##[1:10] debug_entry);
	c_shift: cover property (!test_out_highz_ind);
	c_id: cover property (reg_rd && reg_addr == DTAP_OFS_IDCODE);
endmodule // dtap_checker
`default_nettype wire

// [sim/dtap_probe.sv]
// Purpose: Debug probe model driving the test port pins.
// Assumes: Link period 48 ns; the link clock idles low between scans.
// Notes:   Scans start and end in the idle state of the port.
`timescale 1ns/100ps
`default_nettype none
module dtap_probe (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst_n,
	input  wire logic tdo
);
	////////////////////////////////
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b0;
	end
	// Serial out is taken just before the rise, long after the last fall.
	task automatic step(input logic m, d, output logic o);
		tms = m;
		tdi = d;
		#24;
		o = tdo;
		tck = 1'b1;
		#24;
		tck = 1'b0;
	endtask
	task automatic reset_tap;
		logic o;
		trst_n = 1'b0;
		#60;
		trst_n = 1'b1;
		step(1'b0, 1'b0, o);
	endtask
	task automatic scan(input logic ir, input int n,
		input logic [31:0] din, output logic [31:0] dout);
		logic o;
		dout = 32'h0;
		step(1'b1, 1'b0, o);
		if (ir)
			step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule // dtap_probe
`default_nettype wire

// [sim/tb_dtap_top.sv]
// Purpose: Self-checking bench of the debug test port.
// Assumes: 5 ns core clock; the probe model runs the link.
// Notes:   Expected values come from straps, writes and a small model.
`timescale 1ns/100ps
`default_nettype none
module tb_dtap_top
	import dtap_pkg::*;
;
	logic        clock, srst, reg_wr, reg_rd, debug_entry, debug_exit;
	logic        probe_debug_irq_in, probe_irq_supported_strap;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d, idw;
	logic [10:0] maker_code_strap;
	logic [15:0] part_code_strap;
	logic [3:0]  revision_code_strap;
	logic        debug_exc_req, in_debug_mode_out, peripheral_reset_req;
	logic        processor_reset_req, soft_reset_enable_out;
	logic        test_clock_in, test_serial_in, test_serial_out;
	logic        test_out_highz_ind, test_mode_select_in, test_port_reset_n;
	int          err_total, checks, cycles, m_pend, m_dbg;
	dtap_top i_dtap_top (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .debug_entry, .debug_exit, .debug_exc_req,
		.in_debug_mode_out, .probe_debug_irq_in, .probe_irq_supported_strap,
		.maker_code_strap, .part_code_strap, .revision_code_strap,
		.peripheral_reset_req, .processor_reset_req, .soft_reset_enable_out,
		.test_clock_in, .test_serial_in, .test_serial_out, .test_out_highz_ind,
		.test_mode_select_in, .test_port_reset_n);
	dtap_probe i_dtap_probe (.tck(test_clock_in), .tms(test_mode_select_in),
		.tdi(test_serial_in), .trst_n(test_port_reset_n),
		.tdo(test_out_highz_ind ? ~test_serial_out : test_serial_out));
	// A floating serial pad reads inverted, so sampling it shows up.
	////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk32(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		v = reg_rdata;
	endtask
	task automatic core(input logic en, ex);
		@(posedge clock);
		debug_entry <= en;
		debug_exit <= ex;
		@(posedge clock);
		debug_entry <= 1'b0;
		debug_exit <= 1'b0;
	endtask
	task automatic chk_core;
		@(posedge clock);
		chk1(debug_exc_req, m_pend[0]);
		chk1(in_debug_mode_out, m_dbg[0]);
		rd(DTAP_OFS_STATUS, d);
		chk32(d & 32'hF, {28'h0, 1'b0, probe_irq_supported_strap,
			m_pend[0], m_dbg[0]});
	endtask
	////////////////////////////////
	initial begin
		void'($urandom(32'h8ba0));
		{srst, reg_wr, reg_rd, debug_entry, debug_exit} = 5'h10;
		{reg_addr, reg_wdata, probe_debug_irq_in} = 41'h0;
		{cycles, err_total, checks} = 96'h0;
		probe_irq_supported_strap = 1'b1;
		maker_code_strap = 11'($urandom());
		part_code_strap = 16'($urandom());
		revision_code_strap = 4'($urandom());
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		repeat (3) @(posedge clock);
		rd(DTAP_OFS_STATUS, d);
		chk32(d, 32'hC);
		i_dtap_probe.reset_tap();
		chk1(test_out_highz_ind, 1'b1);
		idw = {revision_code_strap, part_code_strap, maker_code_strap,
			DTAP_ID_MARK};
		rd(DTAP_OFS_IDCODE, d);
		chk32(d, idw);
		fork
			i_dtap_probe.scan(1'b0, 32, 32'h0, d);
			begin
				#600;
				chk1(test_out_highz_ind, 1'b0);
			end
		join
		chk32(d, idw);
		repeat (5) @(posedge clock);
		chk1(test_out_highz_ind, 1'b1);
		i_dtap_probe.scan(1'b1, 5, 32'(DTAP_IR_CONTROL), d);
		chk32(d, 32'(DTAP_IR_CAPTURE));
		i_dtap_probe.scan(1'b0, 4, 32'h5, d);
		repeat (5) @(posedge clock);
		chk32({29'h0, soft_reset_enable_out, processor_reset_req,
			peripheral_reset_req}, 32'h5);
		i_dtap_probe.scan(1'b0, 4, 32'h3, d);
		chk32(d, 32'h5);
		i_dtap_probe.scan(1'b1, 5, 32'(DTAP_IR_BYPASS), d);
		chk32(d, 32'(DTAP_IR_CAPTURE));
		i_dtap_probe.scan(1'b0, 2, 32'h1, d);
		chk32(d, 32'h2);
		chk32({29'h0, soft_reset_enable_out, processor_reset_req,
			peripheral_reset_req}, 32'h3);
		i_dtap_probe.reset_tap();
		$display("test link done");
		for (int i = 0; i < 8; i++) begin
			wr(DTAP_OFS_CTRL, {29'($urandom()), 3'(i)});
			@(posedge clock);
			chk32({29'h0, soft_reset_enable_out, processor_reset_req,
				peripheral_reset_req}, 32'(i));
			chk1(in_debug_mode_out, 1'b0);
			rd(DTAP_OFS_CTRL, d);
			chk32(d, 32'(i));
		end
		wr(DTAP_OFS_CTRL, 32'h0);
		rd(8'hFC, d);
		chk32(d, 32'h0);
		$display("test regs done");
		m_pend = 0;
		m_dbg = 0;
		probe_debug_irq_in <= 1'b1;
		repeat (6) @(posedge clock);
		m_pend = 1;
		chk_core();
		core(1'b1, 1'b0);
		m_pend = 0;
		m_dbg = 1;
		chk_core();
		probe_debug_irq_in <= 1'b0;
		repeat (6) @(posedge clock);
		probe_debug_irq_in <= 1'b1;
		repeat (6) @(posedge clock);
		chk_core();
		core(1'b0, 1'b1);
		m_dbg = 0;
		chk_core();
		probe_debug_irq_in <= 1'b0;
		probe_irq_supported_strap <= 1'b0;
		repeat (6) @(posedge clock);
		probe_debug_irq_in <= 1'b1;
		repeat (6) @(posedge clock);
		chk_core();
		$display("test irq done");
		tally_and_finish();
	end
endmodule // tb_dtap_top
bind dtap_top dtap_checker i_dtap_checker (.clock, .srst, .reg_addr, .reg_rd,
	.reg_rdata, .debug_entry, .debug_exit, .debug_exc_req, .in_debug_mode_out,
	.probe_debug_irq_in, .probe_irq_supported_strap, .maker_code_strap,
	.part_code_strap, .revision_code_strap, .peripheral_reset_req,
	.processor_reset_req, .soft_reset_enable_out, .test_out_highz_ind,
	.test_port_reset_n);
`default_nettype wire
